// [hw/sgp_pkg.sv]
// Package for the seven-bit general-purpose port: widths, reset values, carrier types
// Summary of operation
// [R1] The port has seven pins, each with its own direction, output, strength and pull setting.
// [R2] After reset every pin is an input with its pull resistor enabled toward the supply.
// [R3] Each pin can raise an interrupt on a falling or a rising edge, chosen per pin.
// [R4] In stop mode any enabled pin interrupt raises the wake request.
// [R5] One direction bit per pin selects input or driven output.
// [R6] For an output pin the output bit sets the driven level.
// [R7] Reading the output register returns the stored output values whatever the direction.
// [R8] The level register is read-only and always shows the current pin levels.
// [R9] For an output pin the strength bit selects the low or the high drive current.
// [R10] For an input pin the output bit enables or disables its pull resistor.
// [R11] The pull-direction bit selects pull toward supply or toward ground.
// [R12] Three pins can follow the timer channel instead of the port registers.
// [R13] Each pin has a flag set on its selected edge, an enable gating it, and a software clear.
package sgp_pkg;
	localparam int PIN_COUNT = 7;
	typedef logic [PIN_COUNT-1:0] sgp_pins_t;
	localparam sgp_pins_t DIR_RESET    = 7'h00;
	localparam sgp_pins_t OUT_RESET    = 7'h7f;
	localparam sgp_pins_t STR_RESET    = 7'h00;
	localparam sgp_pins_t PULL_RESET   = 7'h7f;
	localparam sgp_pins_t EDGE_RESET   = 7'h00;
	localparam sgp_pins_t IEN_RESET    = 7'h00;
	// Pins with a timer function: indexes 3, 4 and 6
	localparam sgp_pins_t ALT_CAPABLE  = 7'h58;
	// Synchroniser starts at the pulled-up idle level, no false edge after reset
	localparam logic [1:0] SYNC_RESET  = 2'h3;

	typedef struct packed {
		sgp_pins_t dir;
		sgp_pins_t out;
		sgp_pins_t strength;
		sgp_pins_t pull_up;
		sgp_pins_t edge_rise;
		sgp_pins_t irq_en;
		sgp_pins_t alt_en;
	} sgp_cfg_t;

	typedef struct packed {
		sgp_pins_t oe;
		sgp_pins_t o;
		sgp_pins_t drive_high;
		sgp_pins_t pull_en;
		sgp_pins_t pull_up;
	} sgp_pad_t;
endpackage

// [hw/sgp_sync.sv]
// Two-stage synchroniser for one pin level
`timescale 1ns/100ps
module sgp_sync (
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	input  wire logic i_async,
	output logic      o_sync
);
	import sgp_pkg::*;
	logic [1:0] stage_r;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage_r <= SYNC_RESET;
		end else begin
			stage_r <= {stage_r[0], i_async};
		end
	end

	assign o_sync = stage_r[1];
endmodule // sgp_sync

// [hw/sgp_port.sv]
// Seven-bit general-purpose port: configuration, pad control, level sampling, edge flags
`timescale 1ns/100ps
module sgp_port (
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	input  wire sgp_pkg::sgp_cfg_t  i_cfg_wdata,
	input  wire logic               i_cfg_we,
	input  wire sgp_pkg::sgp_pins_t i_flag_clear,
	input  wire logic               i_stop_mode,
	input  wire sgp_pkg::sgp_pins_t i_pin_in,
	input  wire sgp_pkg::sgp_pins_t i_alt_oe,
	input  wire sgp_pkg::sgp_pins_t i_alt_out,
	output sgp_pkg::sgp_cfg_t       o_cfg_rdata,
	output sgp_pkg::sgp_pins_t      o_pin_level,
	output sgp_pkg::sgp_pins_t      o_alt_in,
	output sgp_pkg::sgp_pad_t       o_pad,
	output sgp_pkg::sgp_pins_t      o_pin_out,
	output sgp_pkg::sgp_pins_t      o_pin_oe,
	output sgp_pkg::sgp_pins_t      o_irq_flag,
	output logic                    o_irq,
	output logic                    o_wake
);
	import sgp_pkg::*;

	sgp_cfg_t  cfg_r;
	sgp_cfg_t  cfg_nxt;
	sgp_pins_t sync_w;
	sgp_pins_t level_r;
	sgp_pins_t prev_r;
	sgp_pins_t flag_r;
	sgp_pins_t flag_nxt;
	sgp_pad_t  pad_r;
	sgp_pad_t  pad_nxt;
	sgp_pins_t alt_in_r;
	logic      irq_r;
	logic      wake_r;

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g++) begin : g_sync
			sgp_sync u_sync (
				.i_clock   (i_clock),
				.i_reset_n (i_reset_n),
				.i_async   (i_pin_in[g]),
				.o_sync    (sync_w[g])
			);
		end
	endgenerate

	// Alternate enable only sticks on the timer-capable pins
	always_comb begin
		cfg_nxt        = i_cfg_we ? i_cfg_wdata : cfg_r;
		cfg_nxt.alt_en = cfg_nxt.alt_en & ALT_CAPABLE; // [R12]
	end

	wire sgp_pins_t alt_sel_w  = cfg_r.alt_en;
	wire sgp_pins_t port_oe_w  = cfg_r.dir; // [R5]
	wire sgp_pins_t oe_w       = (alt_sel_w & i_alt_oe) | (~alt_sel_w & port_oe_w); // [R12]
	wire sgp_pins_t out_w      = (alt_sel_w & i_alt_out) | (~alt_sel_w & cfg_r.out); // [R6]
	wire sgp_pins_t rise_w     = level_r & ~prev_r;
	wire sgp_pins_t fall_w     = ~level_r & prev_r;
	wire sgp_pins_t edge_w     = (cfg_r.edge_rise & rise_w) | (~cfg_r.edge_rise & fall_w); // [R3]
	wire sgp_pins_t pending_w  = flag_r & cfg_r.irq_en;

	always_comb begin
		pad_nxt.oe         = oe_w;
		pad_nxt.o          = out_w & oe_w;
		pad_nxt.drive_high = cfg_r.strength & oe_w; // [R9]
		pad_nxt.pull_en    = cfg_r.out & ~oe_w; // [R10]
		pad_nxt.pull_up    = cfg_r.pull_up; // [R11]
		flag_nxt           = (flag_r & ~i_flag_clear) | edge_w; // [R13]
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_r <= '{dir: DIR_RESET, out: OUT_RESET, strength: STR_RESET, // [R2]
				pull_up: PULL_RESET, edge_rise: EDGE_RESET, irq_en: IEN_RESET,
				alt_en: DIR_RESET};
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Level, previous level and timer-side copy
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			level_r  <= OUT_RESET;
			prev_r   <= OUT_RESET;
			// Plain pins read zero on the timer side
			alt_in_r <= OUT_RESET & ALT_CAPABLE;
		end else begin
			level_r  <= sync_w; // [R8]
			prev_r   <= level_r;
			alt_in_r <= level_r & ALT_CAPABLE;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flag_r <= IEN_RESET;
			irq_r  <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			irq_r  <= |(flag_nxt & cfg_r.irq_en);
			wake_r <= i_stop_mode & |(flag_nxt & cfg_r.irq_en); // [R4]
		end
	end

	// Pads follow the configuration one cycle later
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pad_r <= '{oe: DIR_RESET, o: DIR_RESET, drive_high: STR_RESET,
				pull_en: OUT_RESET, pull_up: PULL_RESET}; // [R2]
		end else begin
			pad_r <= pad_nxt; // [R1]
		end
	end

	assign o_cfg_rdata = cfg_r; // [R7]
	assign o_pin_level = level_r;
	assign o_alt_in    = alt_in_r;
	assign o_pad       = pad_r;
	assign o_pin_out   = pad_r.o;
	assign o_pin_oe    = pad_r.oe;
	assign o_irq_flag  = flag_r;
	assign o_irq       = irq_r;
	assign o_wake      = wake_r;

	// Assertions
	reset_pull_a: assert property (@(posedge i_clock) // [R2]
		$rose(i_reset_n) |-> (pad_r.pull_en == OUT_RESET) && (pad_r.oe == DIR_RESET))
		else $error("pins not inputs with pull after reset");

	// Edge flags
	flag_set_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		(edge_w != 7'h00) |=> ((flag_r & $past(edge_w)) == $past(edge_w)))
		else $error("edge did not set flag");
	rise_sel_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R3]
		(rise_w[0] && cfg_r.edge_rise[0]) |=> flag_r[0])
		else $error("rising edge missed");
	fall_sel_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R3]
		(fall_w[0] && !cfg_r.edge_rise[0] && !flag_r[0]) |=> flag_r[0])
		else $error("falling edge missed");
	no_edge_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R3]
		((edge_w == 7'h00) && (i_flag_clear == 7'h7f)) |=> (flag_r == 7'h00))
		else $error("flag without edge");
	flag_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		(flag_r[0] && !i_flag_clear[0]) |=> flag_r[0])
		else $error("flag lost without clear");
	flag_clear_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		(i_flag_clear[0] && !edge_w[0]) |=> !flag_r[0])
		else $error("flag not cleared");
	set_wins_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		(i_flag_clear[0] && edge_w[0]) |=> flag_r[0])
		else $error("clear beat a new edge");
	irq_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
		o_irq |-> (o_irq_flag != 7'h00))
		else $error("request without flag");

	// Wake from stop mode
	wake_stop_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R4]
		(i_stop_mode && |(flag_nxt & cfg_r.irq_en)) |=> o_wake)
		else $error("no wake in stop mode");
	wake_gate_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R4]
		!i_stop_mode |=> !o_wake)
		else $error("wake outside stop mode");
	wake_irq_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R4]
		o_wake |-> o_irq)
		else $error("wake without enabled flag");

	// Configuration readback
	readback_out_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R7]
		i_cfg_we |=> (o_cfg_rdata.out == $past(i_cfg_wdata.out)))
		else $error("output buffer readback wrong");
	readback_dir_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R5]
		i_cfg_we |=> (o_cfg_rdata.dir == $past(i_cfg_wdata.dir)))
		else $error("direction readback wrong");
	cfg_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R7]
		!i_cfg_we |=> (o_cfg_rdata == $past(o_cfg_rdata)))
		else $error("configuration changed without write");

	// Pad control
	dir_oe_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R5]
		(cfg_r.alt_en == 7'h00) |=> (pad_r.oe == $past(cfg_r.dir)))
		else $error("direction not applied");
	out_level_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R6]
		(cfg_r.alt_en == 7'h00) |=> (pad_r.o == ($past(cfg_r.out) & $past(cfg_r.dir))))
		else $error("output level wrong");
	pull_input_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R10]
		1'b1 |=> (pad_r.pull_en & pad_r.oe) == 7'h00)
		else $error("pull on driven pin");
	pull_enable_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R10]
		(cfg_r.alt_en == 7'h00) |=> (pad_r.pull_en == ($past(cfg_r.out) & ~$past(cfg_r.dir))))
		else $error("pull enable wrong");
	pull_dir_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R11]
		1'b1 |=> (pad_r.pull_up == $past(cfg_r.pull_up)))
		else $error("pull direction wrong");
	strength_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R9]
		1'b1 |=> (pad_r.drive_high == ($past(cfg_r.strength) & $past(oe_w))))
		else $error("strength wrong");

	// Levels and timer function
	level_track_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R8]
		1'b1 |-> ##3 (level_r == $past(i_pin_in, 3)))
		else $error("level register lags");
	alt_only_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R12]
		(cfg_r.alt_en & ~ALT_CAPABLE) == 7'h00)
		else $error("alternate on plain pin");
	alt_route_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R12]
		cfg_r.alt_en[6] |=> (pad_r.oe[6] == $past(i_alt_oe[6])))
		else $error("timer drive not routed");
	alt_in_mask_a: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R12]
		(o_alt_in & ~ALT_CAPABLE) == 7'h00)
		else $error("timer input on plain pin");

	flag_cov_c: cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(flag_r[0]));
	wake_cov_c: cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(o_wake));
	alt_cov_c:  cover property (@(posedge i_clock) disable iff (!i_reset_n) alt_sel_w[6] && i_alt_oe[6]);
	clr_cov_c:  cover property (@(posedge i_clock) disable iff (!i_reset_n) (i_flag_clear & flag_r) != 7'h00);
	pull_cov_c: cover property (@(posedge i_clock) disable iff (!i_reset_n) pad_r.pull_en[0] && !pad_r.pull_up[0]);
endmodule // sgp_port

// [test/sgp_board.sv]
// Board model: pin levels from pad control and board drive
`timescale 1ns/100ps
module sgp_board (
	input  wire logic               i_clock,
	input  wire sgp_pkg::sgp_pad_t  i_pad,
	input  wire sgp_pkg::sgp_pins_t i_ext_oe,
	input  wire sgp_pkg::sgp_pins_t i_ext_val,
	output sgp_pkg::sgp_pins_t      o_wire
);
	import sgp_pkg::*;
	logic toggle_r = 1'b0;
	// Floating pins wander every cycle
	always @(posedge i_clock) toggle_r <= ~toggle_r;
	always_comb begin
		for (int n = 0; n < PIN_COUNT; n++) begin
			if (i_ext_oe[n])
				o_wire[n] = i_ext_val[n];
			else if (i_pad.oe[n])
				o_wire[n] = i_pad.o[n];
			else if (i_pad.pull_en[n])
				o_wire[n] = i_pad.pull_up[n];
			else
				o_wire[n] = toggle_r;
		end
	end
endmodule // sgp_board

// [test/tb_top.sv]
// Testbench: random port setups and pin edges against a bench model
`timescale 1ns/100ps
module tb_top;
	import sgp_pkg::*;
	logic      i_clock = 0, i_reset_n = 0, we = 0, stop = 0, irq, wake;
	sgp_cfg_t  c, rd, n;
	sgp_pins_t clr = 0, aoe = 0, aout = 0, eoe = 0, ev = 0;
	sgp_pins_t w, lvl, ain, pout, poe, fl, ea, oe, o, xw, t, nv, ex, na, nu, ne;
	sgp_pad_t  pad;
	int        fails = 0, samples_checked = 0, cyc = 0;
	always #20 i_clock = ~i_clock;
	sgp_port i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_cfg_wdata(c),
		.i_cfg_we(we), .i_flag_clear(clr), .i_stop_mode(stop), .i_pin_in(w),
		.i_alt_oe(aoe), .i_alt_out(aout), .o_cfg_rdata(rd), .o_pin_level(lvl),
		.o_alt_in(ain), .o_pad(pad), .o_pin_out(pout), .o_pin_oe(poe),
		.o_irq_flag(fl), .o_irq(irq), .o_wake(wake));
	sgp_board i_board (.i_clock(i_clock), .i_pad(pad), .i_ext_oe(eoe),
		.i_ext_val(ev), .o_wire(w));
	task automatic chk(input logic [48:0] s, input logic [48:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("BAD t=%0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test;
		end
	end
	initial begin
		c = '0;
		void'($urandom(76260));
		repeat (3) @(posedge i_clock);
		i_reset_n <= 1'b1;
		#1;
		chk(rd, {DIR_RESET, OUT_RESET, STR_RESET, PULL_RESET, EDGE_RESET, IEN_RESET, 7'h00});
		chk(pad.pull_en & pad.pull_up & ~poe, 7'h7f);
		$display("reset test done");
		repeat (40) begin
			@(posedge i_clock);
			n = 49'({$urandom(), $urandom()});
			{na, nu, ne} = 21'($urandom());
			ea = n.alt_en & ALT_CAPABLE;
			oe = (n.dir & ~ea) | (na & ea);
			o = (n.out & ~ea) | (nu & ea);
			t = 7'($urandom());
			c <= n;
			we <= 1'b1;
			clr <= 7'h7f;
			aoe <= na;
			aout <= nu;
			eoe <= ~oe & (t | ~n.out);
			ev <= ne;
			@(posedge i_clock);
			we <= 1'b0;
			repeat (8) @(posedge i_clock);
			#1;
			xw = (eoe & ev) | (oe & o) | (~eoe & ~oe & n.pull_up);
			chk(rd, {n[48:7], ea});
			chk({poe, pout & oe, pad.drive_high & oe}, {oe, o & oe, n.strength & oe});
			chk({pad.pull_en, pad.pull_up}, {n.out & ~oe, n.pull_up});
			chk({lvl, ain}, {xw, xw & ALT_CAPABLE});
			t = eoe & 7'($urandom());
			nv = ev ^ t;
			@(posedge i_clock);
			clr <= 7'h00;
			ev <= nv;
			stop <= 1'($urandom());
			repeat (8) @(posedge i_clock);
			#1;
			ex = t & ~(nv ^ n.edge_rise);
			chk(fl, ex);
			chk({irq, wake}, {|(ex & n.irq_en), stop & |(ex & n.irq_en)});
			$display("config test done");
		end
		end_of_test;
	end
endmodule // tb_top
